//--- hw/cidm_defs.svh
// Offsets, field positions and reset values of the context ID mask block
`ifndef CIDM_DEFS_SVH
`define CIDM_DEFS_SVH
`define CIDM_OFS_MASK    8'h00
`define CIDM_OFS_VAL0    8'h04
`define CIDM_OFS_VAL1    8'h08
`define CIDM_OFS_VAL2    8'h0C
`define CIDM_OFS_VAL3    8'h10
`define CIDM_OFS_STAT    8'h14
`define CIDM_CMP3_LSB    24
`define CIDM_CMP2_LSB    16
`define CIDM_CMP1_LSB    8
`define CIDM_CMP0_LSB    0
`define CIDM_FIELD_W     8
`define CIDM_STAT_HIT    0
`define CIDM_STAT_NUM    4
`define CIDM_STAT_EN     8
`define CIDM_STAT_IDLE   9
`define CIDM_RST_MASK    32'h0000_0000
`define CIDM_RST_VAL     32'h0000_0000
`define CIDM_RESP_OKAY   2'h0
`define CIDM_RESP_SLVERR 2'h2
`endif

//--- hw/cidm_pkg.sv
// Types shared by the context ID mask block
package cidm_pkg;
  typedef logic [3:0][7:0]  cidm_mask_t;
  typedef logic [3:0][31:0] cidm_value_t;

  typedef enum {
    CIDM_SEL_MASK,
    CIDM_SEL_VAL,
    CIDM_SEL_STAT,
    CIDM_SEL_NONE
  } cidm_sel_e;

  typedef struct packed {
    logic [3:0] hit;
  } cidm_match_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        aw_have;
    logic [7:0]  aw_addr;
    logic        w_have;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    cidm_mask_t  mask;
    cidm_value_t value;
  } cidm_regs_s;
endpackage

//--- hw/cidm_match.sv
// Byte-masked context ID comparators
`timescale 1ns/1ps
module cidm_match
  import cidm_pkg::*;
#(
  parameter int NUM_CMP = 4
)(
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        ce,
  input  wire logic [31:0] ctx_id,
  input  wire cidm_mask_t  mask,
  input  wire cidm_value_t value,
  output logic [3:0]       hit
);
  cidm_match_s st_q;
  cidm_match_s st_d;
  logic [3:0]  hit_calc;

  function automatic logic [3:0] cmp_hit(input cidm_mask_t m, input cidm_value_t v,
                                         input logic [31:0] c);
    cmp_hit = '0;
    for (int n = 0; n < 4; n++)
    begin
      cmp_hit[n] = (n < NUM_CMP);
      for (int b = 0; b < 4; b++)
      begin
        if (!m[n][b] && (v[n][b*8 +: 8] != c[b*8 +: 8]))
        begin
          cmp_hit[n] = 1'b0; // [R5] [R6] [R12]
        end
      end
    end
  endfunction

  always_comb
  begin
    st_d = st_q;
    if (ce)
    begin
      st_d.hit = cmp_hit(mask, value, ctx_id); // [R12]
    end
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign hit = st_q.hit;
  assign hit_calc = cmp_hit(mask, value, ctx_id);

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  match_all_a: assert property (ce && !reset |=> hit == $past(hit_calc)) // [R12]
    else $error("comparator result does not follow masked compare");
  cmp_equal_a: assert property (ce && !reset && value[0] == ctx_id |=> hit[0]) // [R12]
    else $error("comparator with equal value did not match");
  byte_used_a: assert property (ce && !mask[0][0] && value[0][7:0] != ctx_id[7:0] |=> !hit[0]) // [R5]
    else $error("unmasked differing byte still matched");
  byte_ignored_a: assert property (ce && mask[0][3:0] == 4'hF |=> hit[0]) // [R6]
    else $error("fully masked comparator failed to match");
endmodule

//--- hw/cidm_top.sv
// Context ID comparator byte mask register block with AXI4-Lite slave
// Notes on behaviour
// [R1] Bits 31:24 mask comparator 3 bytes
// [R2] Bits 23:16 mask comparator 2 bytes
// [R3] Bits 15:8 mask comparator 1 bytes
// [R4] Bits 7:0 mask comparator 0 bytes
// [R5] Clear mask bit: byte takes part
// [R6] Set mask bit k: byte k ignored
// [R7] Comparator 3 field needs four comparators
// [R8] Comparator 2 field needs three comparators
// [R9] Comparator 1 field needs two comparators
// [R10] Software zeroes value bytes it masks
// [R11] Writes ignored while trace enabled or busy
// [R12] Match needs all unmasked bytes equal
`timescale 1ns/1ps
`include "cidm_defs.svh"
module cidm_top
  import cidm_pkg::*;
#(
  parameter int NUM_CMP = 4
)(
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        ce,
  input  wire logic        trace_enabled,
  input  wire logic        trace_idle,
  input  wire logic [31:0] ctx_id,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [3:0]       cmp_match
);
  cidm_regs_s  st_q;
  cidm_regs_s  st_d;
  cidm_mask_t  mask_eff;
  cidm_sel_e   wr_sel;
  cidm_sel_e   rd_sel;
  logic [1:0]  wr_idx;
  logic [1:0]  rd_idx;
  logic        locked;
  logic        wr_go;

  // Word decode, low two address bits ignored
  function automatic cidm_sel_e reg_sel(input logic [7:0] a);
    case ({a[7:2], 2'h0})
      `CIDM_OFS_MASK: reg_sel = CIDM_SEL_MASK;
      `CIDM_OFS_VAL0,
      `CIDM_OFS_VAL1,
      `CIDM_OFS_VAL2,
      `CIDM_OFS_VAL3: reg_sel = CIDM_SEL_VAL;
      `CIDM_OFS_STAT: reg_sel = CIDM_SEL_STAT;
      default:        reg_sel = CIDM_SEL_NONE;
    endcase
  endfunction

  function automatic logic [1:0] val_idx(input logic [7:0] a);
    val_idx = 2'(a[7:2] - 6'h01);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb);
    merge = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        merge[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
  endfunction

  // Fields of absent comparators stay zero
  function automatic logic [31:0] impl_bits(input int n);
    impl_bits = '0;
    if (n > 0) impl_bits[`CIDM_CMP0_LSB +: `CIDM_FIELD_W] = 8'hFF; // [R4]
    if (n > 1) impl_bits[`CIDM_CMP1_LSB +: `CIDM_FIELD_W] = 8'hFF; // [R3] [R9]
    if (n > 2) impl_bits[`CIDM_CMP2_LSB +: `CIDM_FIELD_W] = 8'hFF; // [R2] [R8]
    if (n > 3) impl_bits[`CIDM_CMP3_LSB +: `CIDM_FIELD_W] = 8'hFF; // [R1] [R7]
  endfunction

  localparam logic [31:0] IMPL = impl_bits(NUM_CMP);
  localparam logic [2:0]  NUM3 = 3'(NUM_CMP);

  assign locked   = trace_enabled || !trace_idle; // [R11]
  assign wr_sel   = reg_sel(st_q.aw_addr);
  assign rd_sel   = reg_sel(s_axi_araddr);
  assign wr_idx   = val_idx(st_q.aw_addr);
  assign rd_idx   = val_idx(s_axi_araddr);
  assign wr_go    = st_q.aw_have && st_q.w_have && !st_q.bvalid;
  assign mask_eff = st_q.mask & IMPL;

  always_comb
  begin
    st_d = st_q;
    if (ce)
    begin
      if (s_axi_awvalid && st_q.awready)
      begin
        st_d.aw_have = 1'b1;
        st_d.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && st_q.wready)
      begin
        st_d.w_have = 1'b1;
        st_d.w_data = s_axi_wdata;
        st_d.w_strb = s_axi_wstrb;
      end
      if (st_q.bvalid && s_axi_bready)
      begin
        st_d.bvalid = 1'b0;
      end
      if (wr_go)
      begin
        st_d.aw_have = 1'b0;
        st_d.w_have  = 1'b0;
        st_d.bvalid  = 1'b1;
        st_d.bresp   = `CIDM_RESP_OKAY;
        case (wr_sel)
          CIDM_SEL_MASK:
          begin
            if (!locked) // [R11]
            begin
              st_d.mask = merge(st_q.mask, st_q.w_data, st_q.w_strb) & IMPL; // [R1] [R7]
            end
          end
          CIDM_SEL_VAL:
          begin
            if (!locked && (wr_idx < NUM_CMP)) // [R11]
            begin
              st_d.value[wr_idx] = merge(st_q.value[wr_idx], st_q.w_data, st_q.w_strb);
            end
          end
          CIDM_SEL_STAT:
          begin
            st_d.bresp = `CIDM_RESP_OKAY;
          end
          default:
          begin
            st_d.bresp = `CIDM_RESP_SLVERR;
          end
        endcase
      end
      st_d.awready = !st_d.aw_have && !st_d.bvalid;
      st_d.wready  = !st_d.w_have && !st_d.bvalid;

      if (st_q.rvalid && s_axi_rready)
      begin
        st_d.rvalid = 1'b0;
      end
      if (s_axi_arvalid && st_q.arready)
      begin
        st_d.rvalid = 1'b1;
        st_d.rresp  = `CIDM_RESP_OKAY;
        st_d.rdata  = '0;
        case (rd_sel)
          CIDM_SEL_MASK:
          begin
            st_d.rdata = mask_eff; // [R8] [R9]
          end
          CIDM_SEL_VAL:
          begin
            st_d.rdata = st_q.value[rd_idx];
          end
          CIDM_SEL_STAT:
          begin
            st_d.rdata[`CIDM_STAT_HIT +: 4] = cmp_match;
            st_d.rdata[`CIDM_STAT_NUM +: 3] = NUM3;
            st_d.rdata[`CIDM_STAT_EN]       = trace_enabled;
            st_d.rdata[`CIDM_STAT_IDLE]     = trace_idle;
          end
          default:
          begin
            st_d.rresp = `CIDM_RESP_SLVERR;
          end
        endcase
      end
      st_d.arready = !st_d.rvalid;
    end
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      st_q       <= '0;
      st_q.mask  <= `CIDM_RST_MASK;
      st_q.value <= {4{`CIDM_RST_VAL}};
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // Software must zero each masked value byte
  cidm_match #(
    .NUM_CMP (NUM_CMP)
  ) u_match (
    .ref_clk (ref_clk),
    .reset   (reset),
    .ce      (ce),
    .ctx_id  (ctx_id),
    .mask    (mask_eff), // [R5] [R6] [R10]
    .value   (st_q.value),
    .hit     (cmp_match)
  );

  assign s_axi_awready = st_q.awready;
  assign s_axi_wready  = st_q.wready;
  assign s_axi_bvalid  = st_q.bvalid;
  assign s_axi_bresp   = st_q.bresp;
  assign s_axi_arready = st_q.arready;
  assign s_axi_rvalid  = st_q.rvalid;
  assign s_axi_rdata   = st_q.rdata;
  assign s_axi_rresp   = st_q.rresp;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence wr_fire;
    ce && wr_go;
  endsequence

  sequence mask_full_wr;
    wr_fire ##0 (wr_sel == CIDM_SEL_MASK && !locked && st_q.w_strb == 4'hF);
  endsequence

  wr_resp_a: assert property (wr_fire |=> s_axi_bvalid)
    else $error("write not answered");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rd_resp_a: assert property (ce && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed while stalled");
  ar_stall_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while read pending");
  mask_write_a: assert property (mask_full_wr |=> st_q.mask == ($past(st_q.w_data) & IMPL)) // [R1] [R2] [R3] [R4]
    else $error("mask register did not take write");
  write_lock_a: assert property (ce && locked |=> $stable(st_q.mask)) // [R11]
    else $error("mask changed while trace unit busy");
  res_zero_a: assert property ((st_q.mask & ~IMPL) == 32'h0000_0000) // [R7] [R8] [R9]
    else $error("absent comparator field not zero");
  unmapped_a: assert property (wr_fire ##0 wr_sel == CIDM_SEL_NONE |=> s_axi_bresp == `CIDM_RESP_SLVERR)
    else $error("unmapped write not refused");
endmodule

//--- tb/cidm_core_model.sv
// Core model presenting the current context ID
`timescale 1ns/1ps
module cidm_core_model
(
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic [31:0] next_id,
  output logic      [31:0] ctx_id
);
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      ctx_id <= 32'h0;
    else
      ctx_id <= next_id;
  end
endmodule

//--- tb/tb.sv
// Self-checking bench for the context ID byte mask block
`timescale 1ns/1ps
`include "cidm_defs.svh"
module tb
  import cidm_pkg::*;
;
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic        ce = 1'b1;
  logic        trace_enabled = 1'b0;
  logic        trace_idle = 1'b1;
  logic [31:0] next_id = 32'h0;
  logic [31:0] ctx_id;
  logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  wstrb = 4'h0, cmp_match;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  int          fail_count = 0, total_checks = 0, cycles = 0;

  always #2 ref_clk = ~ref_clk;

  cidm_core_model core (.ref_clk(ref_clk), .reset(reset), .next_id(next_id), .ctx_id(ctx_id));

  cidm_top #(.NUM_CMP(3)) dut
  (
    .ref_clk(ref_clk), .reset(reset), .ce(ce),
    .trace_enabled(trace_enabled), .trace_idle(trace_idle), .ctx_id(ctx_id),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cmp_match(cmp_match)
  );

  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (!bvalid);
    // Response left waiting one cycle before it is taken
    bready <= 1'b1;
    @(posedge ref_clk);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, r});
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do
    begin
      @(posedge ref_clk);
    end
    while (!arready);
    arvalid <= 1'b0;
    do
    begin
      @(posedge ref_clk);
    end
    while (!rvalid);
    // Read data left waiting one cycle before it is taken
    rready <= 1'b1;
    @(posedge ref_clk);
    rready <= 1'b0;
    chk(rdata, e);
    chk({30'h0, rresp}, {30'h0, r});
    @(posedge ref_clk);
  endtask

  // Field layout with three comparators: top field absent
  task automatic reg_test;
    rd(`CIDM_OFS_MASK, `CIDM_RST_MASK, `CIDM_RESP_OKAY);
    wr(`CIDM_OFS_MASK, 32'hA5C3_3C5A, 4'hF, `CIDM_RESP_OKAY);
    rd(`CIDM_OFS_MASK, 32'h00C3_3C5A, `CIDM_RESP_OKAY);
    rd(8'h40, 32'h0, `CIDM_RESP_SLVERR);
    wr(8'h40, 32'h0000_0001, 4'hF, `CIDM_RESP_SLVERR);
  endtask

  // Writes dropped while enabled or busy
  task automatic lock_test;
    for (int i = 0; i < 2; i++)
    begin
      trace_enabled <= (i == 0);
      trace_idle <= (i == 0);
      wr(`CIDM_OFS_MASK, 32'hFFFF_FFFF, 4'hF, `CIDM_RESP_OKAY);
      rd(`CIDM_OFS_MASK, 32'h00C3_3C5A, `CIDM_RESP_OKAY);
    end
    trace_enabled <= 1'b0;
    trace_idle <= 1'b1;
    @(posedge ref_clk);
  endtask

  // Each comparator ignores one byte, a different one each
  task automatic match_test;
    logic [31:0] ids [5] = '{32'h1122_3344, 32'h1122_33FF, 32'h1122_FF44,
                             32'h11FF_3344, 32'hFF22_3344};
    logic [3:0]  exps [5] = '{4'h7, 4'h1, 4'h2, 4'h4, 4'h0};
    wr(`CIDM_OFS_VAL0, 32'h1122_3300, 4'hF, `CIDM_RESP_OKAY);
    wr(`CIDM_OFS_VAL1, 32'h1122_0044, 4'hF, `CIDM_RESP_OKAY);
    wr(`CIDM_OFS_VAL2, 32'h1100_3344, 4'hF, `CIDM_RESP_OKAY);
    wr(`CIDM_OFS_MASK, 32'h0004_0201, 4'hF, `CIDM_RESP_OKAY);
    for (int i = 0; i < 5; i++)
    begin
      next_id <= ids[i];
      repeat (3) @(posedge ref_clk);
      chk({28'h0, cmp_match}, {28'h0, exps[i]});
    end
  endtask

  // Whole field ignored, nothing ignored, freeze by enable, then readback paths
  task automatic misc_test;
    wr(`CIDM_OFS_MASK, 32'h0000_000F, 4'hF, `CIDM_RESP_OKAY);
    repeat (2) @(posedge ref_clk);
    chk({28'h0, cmp_match}, 32'h0000_0001);
    wr(`CIDM_OFS_MASK, 32'h0000_0000, 4'hF, `CIDM_RESP_OKAY);
    repeat (2) @(posedge ref_clk);
    chk({28'h0, cmp_match}, 32'h0000_0000);
    next_id <= 32'h1122_3300;
    repeat (3) @(posedge ref_clk);
    chk({28'h0, cmp_match}, 32'h0000_0001);
    ce <= 1'b0;
    next_id <= 32'hFF22_3344;
    repeat (3) @(posedge ref_clk);
    chk({28'h0, cmp_match}, 32'h0000_0001);
    ce <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk({28'h0, cmp_match}, 32'h0000_0000);
    wr(`CIDM_OFS_VAL1, 32'h0000_AA00, 4'h2, `CIDM_RESP_OKAY);
    rd(`CIDM_OFS_VAL1, 32'h1122_AA44, `CIDM_RESP_OKAY);
    wr(`CIDM_OFS_VAL3, 32'h1234_5678, 4'hF, `CIDM_RESP_OKAY);
    rd(`CIDM_OFS_VAL3, 32'h0, `CIDM_RESP_OKAY);
    rd(`CIDM_OFS_STAT,
       (32'h3 << `CIDM_STAT_NUM) | (32'h1 << `CIDM_STAT_IDLE),
       `CIDM_RESP_OKAY);
  endtask

  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      fail_count++;
      stop_test();
    end
  end

  initial
  begin
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    reg_test();
    lock_test();
    match_test();
    misc_test();
    stop_test();
  end
endmodule
